/* logic/adrs_map.svh */
// Constants of the converter result serial port.
`ifndef ADRS_MAP_SVH
`define ADRS_MAP_SVH
`define ADRS_RESULT_W      20
`define ADRS_WRITE_CLKS    6
`define ADRS_READY_CLKS    6
`define ADRS_SETTLE_CONVS  6
`define ADRS_TIMER_W       3
`define ADRS_CONV_CNT_W    3
`define ADRS_SYNC_STAGES   3
`endif

/* logic/adrs_pkg.sv */
// Types of the converter result serial port.
package adrs_pkg;
    typedef enum logic [1:0]
    {
        ADRS_MODE_CS_TIED_LOW  = 2'h0,
        ADRS_MODE_CS_USED      = 2'h1,
        ADRS_MODE_CS_HELD_HIGH = 2'h2
    } adrs_mode_t;

    typedef enum logic [1:0]
    {
        ADRS_ST_IDLE  = 2'h0,
        ADRS_ST_WRITE = 2'h1,
        ADRS_ST_WAIT  = 2'h2,
        ADRS_ST_PULSE = 2'h3
    } adrs_state_t;
endpackage

/* logic/adrs_shift_if.sv */
// Link between the ready controller and the result shift register.
`timescale 1ns/1ps
interface adrs_shift_if #(parameter int W = 20);
    logic         load;
    logic [W-1:0] word;
    logic         restart;
    logic         shift;
    logic         dout;

    modport ctl
    (
        output load,
        output word,
        output restart,
        output shift,
        input  dout
    );

    modport shf
    (
        input  load,
        input  word,
        input  restart,
        input  shift,
        output dout
    );
endinterface

/* logic/adrs_shifter.sv */
// Result shift register with serial data output.
`timescale 1ns/1ps
module adrs_shifter #(parameter int W = 20)
(
    input wire logic clk_i,
    input wire logic srst_i,
    adrs_shift_if.shf sh
);
    import adrs_pkg::*;

    logic [W-1:0] held_reg;
    logic [W-1:0] sr_reg;
    logic         dout_reg;

    // ==========================================================
    // Result hold and shift.
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            held_reg <= '0;
            sr_reg   <= '0;
            dout_reg <= 1'b0;
        end
        else if (sh.load)
        begin
            held_reg <= sh.word;
            sr_reg   <= sh.word;
            dout_reg <= sh.word[W-1];
        end
        else if (sh.restart)
        begin
            sr_reg   <= held_reg;
            dout_reg <= held_reg[W-1];
        end
        else if (sh.shift)
        begin
            sr_reg   <= {sr_reg[W-2:0], 1'b0};
            dout_reg <= sr_reg[W-2];
        end
    end

    assign sh.dout = dout_reg;
endmodule

/* logic/adrs_port.sv */
// Serial result port of a 20-bit converter: ready pulse, select and shifted data.
`timescale 1ns/1ps
`include "adrs_map.svh"
module adrs_port #(
    parameter int W           = `ADRS_RESULT_W,
    parameter int WRITE_CLKS  = `ADRS_WRITE_CLKS,
    parameter int READY_CLKS  = `ADRS_READY_CLKS,
    parameter int SETTLE_CONV = `ADRS_SETTLE_CONVS
)
(
    input  wire logic              core_clk_i,
    input  wire logic              srst_i,
    input  wire adrs_pkg::adrs_mode_t ready_mode_i,
    input  wire logic              conv_done_i,
    input  wire logic [W-1:0]      conv_result_i,
    input  wire logic              sclk_i,
    input  wire logic              cs_n_i,
    output logic                   result_ready_n_o,
    output logic                   dout_o,
    output logic                   dout_oe_n_o,
    output logic                   result_settled_o
);
    import adrs_pkg::*;

    localparam logic [`ADRS_TIMER_W-1:0]    WRITE_LAST = (`ADRS_TIMER_W)'(WRITE_CLKS - 1);
    localparam logic [`ADRS_TIMER_W-1:0]    READY_LAST = (`ADRS_TIMER_W)'(READY_CLKS - 1);
    localparam logic [`ADRS_CONV_CNT_W-1:0] SETTLE_CNT = (`ADRS_CONV_CNT_W)'(SETTLE_CONV);

    adrs_shift_if #(.W(W)) sh ();

    // ==========================================================
    // Pin synchronisers for shift clock and select.
    logic [1:0] sync1_reg;
    logic [1:0] sync2_reg;
    logic [1:0] sync3_reg;
    logic [1:0] lvl_reg;
    logic [1:0] lvl_next;
    logic [1:0] prev_reg;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_sync
            always_ff @(posedge core_clk_i)
            begin
                if (srst_i)
                begin
                    sync1_reg[gi] <= (gi == 1) ? 1'b1 : 1'b0;
                    sync2_reg[gi] <= (gi == 1) ? 1'b1 : 1'b0;
                    sync3_reg[gi] <= (gi == 1) ? 1'b1 : 1'b0;
                end
                else
                begin
                    sync1_reg[gi] <= (gi == 1) ? cs_n_i : sclk_i;
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                end
            end

            // A change counts once the second and third stages agree.
            always_comb
            begin
                lvl_next[gi] = (sync2_reg[gi] == sync3_reg[gi]) ? sync3_reg[gi] : lvl_reg[gi];
            end

            always_ff @(posedge core_clk_i)
            begin
                if (srst_i)
                begin
                    lvl_reg[gi]  <= (gi == 1) ? 1'b1 : 1'b0;
                    prev_reg[gi] <= (gi == 1) ? 1'b1 : 1'b0;
                end
                else
                begin
                    lvl_reg[gi]  <= lvl_next[gi];
                    prev_reg[gi] <= lvl_reg[gi];
                end
            end
        end
    endgenerate

    logic sclk_fall;
    logic cs_fall;
    logic selected;

    assign sclk_fall = prev_reg[0] & ~lvl_reg[0];
    assign cs_fall   = prev_reg[1] & ~lvl_reg[1];
    assign selected  = ~lvl_reg[1];

    // ==========================================================
    // Ready sequencing.
    adrs_state_t                  state_reg;
    adrs_state_t                  state_next;
    logic [`ADRS_TIMER_W-1:0]     timer_reg;
    logic [`ADRS_TIMER_W-1:0]     timer_next;
    logic [W-1:0]                 capt_reg;
    logic                         load_now;
    logic                         ready_n_reg;
    logic                         ready_n_next;

    always_comb
    begin
        state_next = state_reg;
        timer_next = timer_reg;
        load_now   = 1'b0;
        unique case (state_reg)
            ADRS_ST_IDLE:
            begin
                if (conv_done_i)
                begin
                    state_next = ADRS_ST_WRITE;
                    timer_next = WRITE_LAST;
                end
            end
            ADRS_ST_WRITE:
            begin
                if (timer_reg == '0)
                begin
                    load_now   = 1'b1;
                    timer_next = READY_LAST;
                    state_next = (ready_mode_i == ADRS_MODE_CS_USED) ? ADRS_ST_WAIT : ADRS_ST_PULSE;
                end
                else
                begin
                    timer_next = timer_reg - 1'b1;
                end
            end
            ADRS_ST_WAIT:
            begin
                if (conv_done_i)
                begin
                    state_next = ADRS_ST_WRITE;
                    timer_next = WRITE_LAST;
                end
                else if (cs_fall)
                begin
                    state_next = ADRS_ST_PULSE;
                    timer_next = READY_LAST;
                end
            end
            ADRS_ST_PULSE:
            begin
                if (conv_done_i)
                begin
                    state_next = ADRS_ST_WRITE;
                    timer_next = WRITE_LAST;
                end
                else if (timer_reg == '0)
                begin
                    state_next = ADRS_ST_IDLE;
                end
                else
                begin
                    timer_next = timer_reg - 1'b1;
                end
            end
        endcase
    end

    always_comb
    begin
        unique case (ready_mode_i)
            ADRS_MODE_CS_USED:
                ready_n_next = ~(state_next == ADRS_ST_WAIT || state_next == ADRS_ST_PULSE);
            ADRS_MODE_CS_HELD_HIGH:
                ready_n_next = (state_next == ADRS_ST_WRITE || state_next == ADRS_ST_PULSE);
            default:
                ready_n_next = (state_next != ADRS_ST_PULSE);
        endcase
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            state_reg   <= ADRS_ST_IDLE;
            timer_reg   <= '0;
            ready_n_reg <= 1'b1;
        end
        else
        begin
            state_reg   <= state_next;
            timer_reg   <= timer_next;
            ready_n_reg <= ready_n_next;
        end
    end

    // Result is captured when the conversion completes, codes kept as given.
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            capt_reg <= '0;
        end
        else if (conv_done_i)
        begin
            capt_reg <= conv_result_i;
        end
    end

    // ==========================================================
    // Settling count of completed conversions.
    logic [`ADRS_CONV_CNT_W-1:0] conv_cnt_reg;

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            conv_cnt_reg <= '0;
        end
        else if (load_now && conv_cnt_reg != SETTLE_CNT)
        begin
            conv_cnt_reg <= conv_cnt_reg + 1'b1;
        end
    end

    assign result_settled_o = (conv_cnt_reg == SETTLE_CNT);

    // ==========================================================
    // Shifter control and pins.
    assign sh.load    = load_now;
    assign sh.word    = capt_reg;
    assign sh.restart = cs_fall;
    assign sh.shift   = sclk_fall & selected;

    adrs_shifter #(.W(W)) u_shifter
    (
        .clk_i  (core_clk_i),
        .srst_i (srst_i),
        .sh     (sh)
    );

    assign result_ready_n_o = ready_n_reg;
    assign dout_o           = sh.dout;
    assign dout_oe_n_o      = lvl_reg[1];
endmodule

/* dv/adrs_port_sva.sv */
// Assertions on the converter result serial port.
`timescale 1ns/1ps
module adrs_port_sva #(parameter int W = 20)
(
    input wire logic                 core_clk_i,
    input wire logic                 srst_i,
    input wire adrs_pkg::adrs_mode_t ready_mode_i,
    input wire logic                 conv_done_i,
    input wire logic [W-1:0]         conv_result_i,
    input wire logic                 sclk_i,
    input wire logic                 cs_n_i,
    input wire logic                 result_ready_n_o,
    input wire logic                 dout_o,
    input wire logic                 dout_oe_n_o,
    input wire logic                 result_settled_o
);
    import adrs_pkg::*;
    logic [2:0]   n_conv_reg;
    logic [W-1:0] word_reg;
    logic         m0, m1, m2;
    // ====================
    // Helper state and checks.
    assign m0 = (ready_mode_i == ADRS_MODE_CS_TIED_LOW);
    assign m1 = (ready_mode_i == ADRS_MODE_CS_USED);
    assign m2 = (ready_mode_i == ADRS_MODE_CS_HELD_HIGH);
    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
            n_conv_reg <= 3'h0;
        else if (conv_done_i && n_conv_reg != 3'h7)
            n_conv_reg <= n_conv_reg + 3'h1;
    end
    always_ff @(posedge core_clk_i)
    begin
        if (conv_done_i)
            word_reg <= conv_result_i;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    a_write_then_low: assert property (!m2 && conv_done_i && result_ready_n_o
        |=> result_ready_n_o [*6] ##1 !result_ready_n_o) else $error("ready not low after write");
    a_ready_pulse_len: assert property (m0 && $fell(result_ready_n_o)
        |-> !result_ready_n_o [*6] ##1 result_ready_n_o) else $error("ready pulse length wrong");
    a_held_high_span: assert property (m2 && conv_done_i && !result_ready_n_o
        |=> result_ready_n_o [*8] ##1 result_ready_n_o [*4] ##1 !result_ready_n_o)
        else $error("ready high span wrong");
    a_select_holds_low: assert property (m1 && !result_ready_n_o && cs_n_i && !conv_done_i
        |=> !result_ready_n_o) else $error("ready rose without select");
    a_select_release: assert property (m1 && $fell(cs_n_i) && !result_ready_n_o
        |-> !result_ready_n_o [*6] ##[1:8] result_ready_n_o) else $error("ready not released");
    a_oe_on_select: assert property ($fell(cs_n_i) |-> ##[2:6] !dout_oe_n_o)
        else $error("output not driven");
    a_oe_on_release: assert property ($rose(cs_n_i) |-> ##[2:6] dout_oe_n_o)
        else $error("output not floated");
    a_msb_on_select: assert property ($fell(dout_oe_n_o) |-> ##[0:1] dout_o == word_reg[W-1])
        else $error("first bit not the top bit");
    a_settled_early: assert property (n_conv_reg < 3'h6 |-> !result_settled_o)
        else $error("settled too early");
    a_settled_sixth: assert property ($rose(n_conv_reg == 3'h6) |-> ##[5:8] result_settled_o)
        else $error("settled missing");
    c_mode0_pulse: cover property (m0 && $fell(result_ready_n_o));
    c_select_read: cover property (m1 && $fell(dout_oe_n_o));
    c_held_high: cover property (m2 && $rose(result_ready_n_o));
endmodule

/* dv/adrs_host.sv */
// Host model that reads results over the serial port.
`timescale 1ns/1ps
module adrs_host
(
    output logic      sclk_o,
    output logic      cs_n_o,
    input  wire logic dout_i,
    input  wire logic oe_n_i
);
    logic line;
    // ====================
    // Pin level and shift clock.
    assign line = oe_n_i ? ~dout_i : dout_i;
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
    end
    task automatic xfer(input int n, input logic sel, output logic [23:0] d);
        d = 24'h0;
        cs_n_o = ~sel;
        #48;
        for (int i = 0; i < n; i++)
        begin
            sclk_o = 1'b1;
            d = {d[22:0], line};
            #32;
            sclk_o = 1'b0;
            #32;
        end
        cs_n_o = 1'b1;
        #48;
    endtask
endmodule

/* dv/adrs_result_serial_port_tb.sv */
// Testbench of the converter result serial port.
`timescale 1ns/1ps
module adrs_result_serial_port_tb;
    import adrs_pkg::*;
    typedef struct {adrs_mode_t m; logic [19:0] r; int n; logic [23:0] e;} adrs_row_t;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    adrs_mode_t  mode = ADRS_MODE_CS_USED;
    logic        done = 1'b0;
    logic [19:0] res = 20'h0;
    logic        sclk, host_cs_n, cs_n, ready_n, dout, oe_n, settled;
    logic [23:0] got;
    int          n_mismatch = 0;
    int          checked = 0;
    adrs_row_t   rows [8] = '{
        '{ADRS_MODE_CS_USED, 20'h00000, 20, 24'h000000}, '{ADRS_MODE_CS_USED, 20'h80000, 24, 24'h800000},
        '{ADRS_MODE_CS_USED, 20'h7FFFF, 20, 24'h07FFFF}, '{ADRS_MODE_CS_TIED_LOW, 20'hA5A5A, 24, 24'hA5A5A0},
        '{ADRS_MODE_CS_TIED_LOW, 20'h12345, 16, 24'h001234}, '{ADRS_MODE_CS_USED, 20'h5A5A5, 16, 24'h005A5A},
        '{ADRS_MODE_CS_USED, 20'hC3C3C, 20, 24'h0C3C3C}, '{ADRS_MODE_CS_HELD_HIGH, 20'h11111, 4, 24'h00000F}};
    // ====================
    // Instances, tasks and tests.
    assign cs_n = (mode == ADRS_MODE_CS_TIED_LOW) ? 1'b0 : host_cs_n;
    always #2 core_clk = ~core_clk;
    adrs_port u_adrs_port (.core_clk_i(core_clk), .srst_i(srst), .ready_mode_i(mode), .conv_done_i(done),
        .conv_result_i(res), .sclk_i(sclk), .cs_n_i(cs_n), .result_ready_n_o(ready_n), .dout_o(dout),
        .dout_oe_n_o(oe_n), .result_settled_o(settled));
    adrs_host u_adrs_host (.sclk_o(sclk), .cs_n_o(host_cs_n), .dout_i(dout), .oe_n_i(oe_n));
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conv(input logic [19:0] r);
        repeat (8) @(negedge core_clk);
        done = 1'b1;
        res = r;
        @(negedge core_clk);
        done = 1'b0;
        repeat (7) @(negedge core_clk);
        check("ready_n in pulse", 24'(ready_n), 24'(mode == ADRS_MODE_CS_HELD_HIGH));
        repeat (6) @(negedge core_clk);
        check("ready_n after pulse", 24'(ready_n), 24'(mode == ADRS_MODE_CS_TIED_LOW));
    endtask
    task automatic final_report;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(negedge core_clk);
        check("reset ready_n", 24'(ready_n), 24'h1);
        check("reset oe_n", 24'(oe_n), 24'h1);
        srst = 1'b0;
        conv(20'h9C3A1);
        u_adrs_host.xfer(4, 1'b0, got);
        u_adrs_host.xfer(20, 1'b1, got);
        check("read after idle clocks", got, 24'h09C3A1);
        for (int i = 0; i < 8; i++)
        begin
            mode = rows[i].m;
            conv(rows[i].r);
            u_adrs_host.xfer(rows[i].n, mode == ADRS_MODE_CS_USED, got);
            check("read data", got, rows[i].e);
            check("ready_n after read", 24'(ready_n), 24'(mode != ADRS_MODE_CS_HELD_HIGH));
        end
        check("held high oe_n", 24'(oe_n), 24'h1);
        check("settled", 24'(settled), 24'h1);
        mode = ADRS_MODE_CS_TIED_LOW;
        conv(20'h3F0F0);
        u_adrs_host.xfer(24, 1'b0, got);
        check("tied low padded", got, 24'h3F0F00);
        check("tied low dout", 24'(dout), 24'h0);
        check("tied low oe_n", 24'(oe_n), 24'h0);
        srst = 1'b1;
        repeat (4) @(negedge core_clk);
        check("second reset settled", 24'(settled), 24'h0);
        check("second reset ready_n", 24'(ready_n), 24'h1);
        srst = 1'b0;
        conv(20'h80001);
        u_adrs_host.xfer(20, 1'b0, got);
        check("read after second reset", got, 24'h080001);
        check("unsettled after reset", 24'(settled), 24'h0);
        final_report;
    end
    initial
    begin
        #100000;
        n_mismatch++;
        final_report;
    end
endmodule
bind adrs_port adrs_port_sva #(.W(W)) u_adrs_port_sva (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .ready_mode_i(ready_mode_i), .conv_done_i(conv_done_i), .conv_result_i(conv_result_i), .sclk_i(sclk_i),
    .cs_n_i(cs_n_i), .result_ready_n_o(result_ready_n_o), .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o),
    .result_settled_o(result_settled_o));
